// ---- verilog/special_register_bank_zero.sv ----
// Purpose: bank-zero special function registers behind an AHB-Lite slave
// Assumes: hresetn is the power-up reset, soft_reset_n the pin/watchdog one
// Notes: register index = data-memory address, byte address = index * 4
`timescale 1ns/10ps
// Notes on behaviour
// R1 - accesses to offset 00h go to the address held in the pointer
// R2 - the window has no storage and reads as zero on reset
// R3 - timer-zero and timer-one bytes are plain storage cells written and read as memory
// R4 - upper buffer holds five writable bits, cleared by every reset
// R5 - timer-one low byte is unknown at power-up, kept over other resets
// R6 - the sixteen-bit timer is two bytes at 0Eh and 0Fh, accessed apart
// R7 - buffer goes into program-counter bits 12..8 on a load, unreadable
// R8 - shared registers answer with the same content from every bank
// R9 - on the 28-pin part ports D and E are absent and read zero
// R10 - unimplemented bits and locations read zero; soft reset is pin/watchdog
// R11 - port writes go to the latch, port reads return the pin levels
module special_register_bank_zero #(
   parameter bit HAS_PORTS_DE = 1'b1
) (
   // clock and resets
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic soft_reset_n,
   input wire logic reset_to_in,
   input wire logic reset_pd_in,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // core side
   input wire logic alu_flag_we,
   input wire logic [2:0] alu_flags,
   input wire logic pc_load,
   input wire logic [7:0] pc_load_low,
   output logic [12:0] pc_value,
   output logic [1:0] bank_select,
   // peripheral side
   input wire logic [2:0] int_flag_set,
   input wire logic [7:0] flags_one_set,
   input wire logic flags_two_set,
   output logic [7:0] interrupt_control_out,
   output logic [7:0] timer_one_control_out,
   output logic [7:0] timer_two_control_out,
   output logic [7:0] timer_two_count_out,
   // indirect data-memory port
   output logic [8:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata,
   // port pins
   input wire logic [7:0] port_a_pins_in,
   input wire logic [7:0] port_b_pins_in,
   input wire logic [7:0] port_c_pins_in,
   input wire logic [7:0] port_d_pins_in,
   input wire logic [7:0] port_e_pins_in,
   output logic [7:0] port_a_latch_out,
   output logic [7:0] port_b_latch_out,
   output logic [7:0] port_c_latch_out,
   output logic [7:0] port_d_latch_out,
   output logic [7:0] port_e_latch_out
);
   import sfr_bank_pkg::*;

   typedef enum {ST_IDLE, ST_WRITE, ST_READ_ISSUE, ST_READ_WAIT, ST_READ_TAKE,
      ST_READ_DONE} bus_state_type;

   bus_state_type state_reg, state_next;
   logic [8:0] acc_addr_reg;
   logic [7:0] hrdata_reg;
   logic [7:0] pc_low_reg, pc_low_next;
   logic [4:0] pc_upper_reg, pc_high_reg;
   logic [7:0] status_reg, status_next;
   logic [7:0] pointer_reg;
   logic [7:0] int_ctrl_reg, int_ctrl_next;
   logic [7:0] flags_one_reg, flags_one_next;
   logic [7:0] flags_two_reg, flags_two_next;
   logic [7:0] t1_ctrl_reg, t2_ctrl_reg, t2_count_reg;
   logic [8:0] mem_addr_reg;
   logic [7:0] mem_wdata_reg;
   logic mem_we_reg, mem_re_reg;
   logic [7:0] ram_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake
   wire accept = hsel && hready && htrans[1];
   wire wr_fire = (state_reg == ST_WRITE);
   wire rd_issue = (state_reg == ST_READ_ISSUE);
   wire rd_take = (state_reg == ST_READ_TAKE);
   wire [7:0] wdata = hwdata[7:0];

   // next bus state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_READ_ISSUE: state_next = ST_READ_WAIT;
         ST_READ_WAIT: state_next = ST_READ_TAKE;
         ST_READ_TAKE: state_next = ST_READ_DONE;
         default: begin
            if (accept) begin
               state_next = hwrite ? ST_WRITE : ST_READ_ISSUE;
            end else begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   // state and captured address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         acc_addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (accept) begin
            acc_addr_reg <= haddr[ADDR_LSB +: MEM_ADDR_W];
         end
      end
   end

   assign hreadyout = !(rd_issue || state_reg == ST_READ_WAIT || rd_take);
   assign hresp = HRESP_OKAY;
   assign hrdata = {24'h000000, hrdata_reg};

   ////////////////////////////////////////////////////////////////////////////
   // target decode: window redirect and bank aliasing
   wire via_window = (acc_addr_reg[6:0] == OFS_WINDOW);
   wire [8:0] tgt = via_window ? {status_reg[STATUS_IRP_BIT], pointer_reg} : acc_addr_reg; // R1
   wire [6:0] tgt_low = tgt[6:0];
   wire tgt_bank0 = (tgt[8:7] == BANK_ZERO);
   wire tgt_shared = (tgt_low == OFS_WINDOW) || (tgt_low == OFS_PC_LOW) ||
      (tgt_low == OFS_STATUS) || (tgt_low == OFS_POINTER) ||
      (tgt_low == OFS_PC_UPPER) || (tgt_low == OFS_INT_CTRL); // R8
   wire local_hit = (tgt_bank0 && tgt_low <= OFS_LAST) || tgt_shared; // R8
   wire ext_hit = via_window && !local_hit; // R1

   // per-register selects (window-to-window selects nothing)
   wire sel_t0 = local_hit && tgt_low == OFS_TIMER_ZERO;
   wire sel_pcl = local_hit && tgt_low == OFS_PC_LOW;
   wire sel_status = local_hit && tgt_low == OFS_STATUS;
   wire sel_pointer = local_hit && tgt_low == OFS_POINTER;
   wire sel_upper = local_hit && tgt_low == OFS_PC_UPPER;
   wire sel_intc = local_hit && tgt_low == OFS_INT_CTRL;
   wire sel_f1 = local_hit && tgt_low == OFS_FLAGS_ONE;
   wire sel_f2 = local_hit && tgt_low == OFS_FLAGS_TWO;
   wire sel_t1l = local_hit && tgt_low == OFS_T1_LOW;
   wire sel_t1h = local_hit && tgt_low == OFS_T1_HIGH;
   wire sel_t1c = local_hit && tgt_low == OFS_T1_CTRL;
   wire sel_t2 = local_hit && tgt_low == OFS_T2_COUNT;
   wire sel_t2c = local_hit && tgt_low == OFS_T2_CTRL;
   wire sel_ram = sel_t0 || sel_t1l || sel_t1h;
   wire [1:0] ram_slot = sel_t1l ? SLOT_T1_LOW : (sel_t1h ? SLOT_T1_HIGH : SLOT_TIMER_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // timer bytes and timer-zero count in storage cells
   sfr_cell_ram #(
      .DEPTH(RAM_DEPTH),
      .ADDR_W(2),
      .WIDTH(DATA_W)
   ) u_cells (
      .hclk(hclk),
      .hresetn(hresetn),
      .write_en(wr_fire && sel_ram), // R3 R6
      .write_addr(ram_slot), // R6
      .write_data(wdata),
      .read_en(rd_issue && sel_ram), // R5 R6
      .read_addr(ram_slot),
      .read_data_reg(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // ports A to E
   logic [7:0] port_pins [PORT_COUNT];
   logic [7:0] port_read [PORT_COUNT];
   logic [7:0] port_latch [PORT_COUNT];
   logic [7:0] port_read_sel;

   assign port_pins = '{port_a_pins_in, port_b_pins_in, port_c_pins_in,
      port_d_pins_in, port_e_pins_in};

   genvar gi;
   generate
      for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
         wire port_sel = local_hit && tgt_bank0 && (tgt_low == 7'(OFS_PORT_A + gi));
         port_latch_block #(
            .WIDTH(PORT_WIDTH[gi]),
            .BUILT((gi < PORT_D_INDEX) || HAS_PORTS_DE) // R9
         ) u_port (
            .hclk(hclk),
            .hresetn(hresetn),
            .write_en(wr_fire && port_sel), // R11
            .write_data(wdata),
            .read_value(port_read[gi]),
            .pins_in(port_pins[gi]),
            .latch_out_reg(port_latch[gi])
         );
      end
   endgenerate

   // read-back of the selected port, zero when none selected
   always_comb begin
      port_read_sel = 8'h00;
      for (int i = 0; i < PORT_COUNT; i++) begin
         if (local_hit && tgt_bank0 && tgt_low == 7'(OFS_PORT_A + i)) begin
            port_read_sel = port_read[i]; // R11
         end
      end
   end

   assign port_a_latch_out = port_latch[0];
   assign port_b_latch_out = port_latch[1];
   assign port_c_latch_out = port_latch[2];
   assign port_d_latch_out = port_latch[3];
   assign port_e_latch_out = port_latch[4];

   ////////////////////////////////////////////////////////////////////////////
   // next values of core and flag registers
   wire [7:0] status_wr = (status_reg & ~STATUS_WR_MASK) | (wdata & STATUS_WR_MASK);
   wire [7:0] status_bus = (wr_fire && sel_status) ? status_wr : status_reg;
   assign status_next = alu_flag_we ? {status_bus[7:3], alu_flags} : status_bus;
   assign pc_low_next = (wr_fire && sel_pcl) ? wdata : pc_load_low;
   // hardware set wins over a clearing write
   assign int_ctrl_next = ((wr_fire && sel_intc) ? wdata : int_ctrl_reg) |
      {5'h00, int_flag_set};
   wire [7:0] f1_set_mask = HAS_PORTS_DE ? FLAGS_ONE_MASK :
      (FLAGS_ONE_MASK & ~(8'h01 << FLAGS_PSP_BIT));
   assign flags_one_next = (((wr_fire && sel_f1) ? wdata : flags_one_reg) |
      flags_one_set) & f1_set_mask; // R10
   assign flags_two_next = (((wr_fire && sel_f2) ? wdata : flags_two_reg) |
      {3'h0, flags_two_set, 4'h0}) & FLAGS_TWO_MASK; // R10

   // program counter low byte, upper buffer and upper bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_low_reg <= RST_PC_LOW;
         pc_upper_reg <= RST_PC_UPPER; // R4
         pc_high_reg <= RST_PC_UPPER;
      end else if (!soft_reset_n) begin
         pc_low_reg <= RST_PC_LOW; // R10
         pc_upper_reg <= RST_PC_UPPER; // R4
         pc_high_reg <= RST_PC_UPPER;
      end else begin
         if (wr_fire && sel_upper) begin
            pc_upper_reg <= wdata[PC_UPPER_W-1:0]; // R4
         end
         if (pc_load || (wr_fire && sel_pcl)) begin
            pc_low_reg <= pc_low_next;
            pc_high_reg <= pc_upper_reg; // R7
         end
      end
   end

   // status, interrupt control and peripheral flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= RST_STATUS_POR;
         int_ctrl_reg <= RST_INT_CTRL;
         flags_one_reg <= RST_FLAGS;
         flags_two_reg <= RST_FLAGS;
      end else if (!soft_reset_n) begin
         status_reg <= {3'h0, reset_to_in, reset_pd_in, status_reg[2:0]}; // R10
         int_ctrl_reg <= {7'h00, int_ctrl_reg[0]}; // R10
         flags_one_reg <= RST_FLAGS;
         flags_two_reg <= RST_FLAGS;
      end else begin
         status_reg <= status_next;
         int_ctrl_reg <= int_ctrl_next;
         flags_one_reg <= flags_one_next;
         flags_two_reg <= flags_two_next;
      end
   end

   // pointer and timer control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pointer_reg <= RST_POINTER;
         t1_ctrl_reg <= RST_T1_CTRL;
         t2_ctrl_reg <= RST_T2_CTRL;
         t2_count_reg <= RST_T2_COUNT;
      end else if (!soft_reset_n) begin
         t2_ctrl_reg <= RST_T2_CTRL; // R10
         t2_count_reg <= RST_T2_COUNT;
      end else begin
         if (wr_fire && sel_pointer) begin
            pointer_reg <= wdata;
         end
         if (wr_fire && sel_t1c) begin
            t1_ctrl_reg <= wdata & T1_CTRL_MASK; // R10
         end
         if (wr_fire && sel_t2c) begin
            t2_ctrl_reg <= wdata & T2_CTRL_MASK; // R10
         end
         if (wr_fire && sel_t2) begin
            t2_count_reg <= wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indirect data-memory port, registered one cycle after the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_addr_reg <= '0;
         mem_wdata_reg <= '0;
         mem_we_reg <= 1'b0;
         mem_re_reg <= 1'b0;
      end else begin
         mem_we_reg <= wr_fire && ext_hit; // R1
         mem_re_reg <= rd_issue && ext_hit; // R1
         if ((wr_fire || rd_issue) && ext_hit) begin
            mem_addr_reg <= tgt;
            mem_wdata_reg <= wdata;
         end
      end
   end

   assign mem_addr = mem_addr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign mem_we = mem_we_reg;
   assign mem_re = mem_re_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read selection; the window itself and gaps read zero
   wire [7:0] read_local =
      ({8{sel_ram}} & ram_rdata) |
      ({8{sel_pcl}} & pc_low_reg) |
      ({8{sel_status}} & status_reg) |
      ({8{sel_pointer}} & pointer_reg) |
      ({8{sel_upper}} & {3'h0, pc_upper_reg}) | // R4 R7
      ({8{sel_intc}} & int_ctrl_reg) |
      ({8{sel_f1}} & flags_one_reg) |
      ({8{sel_f2}} & flags_two_reg) |
      ({8{sel_t1c}} & t1_ctrl_reg) |
      ({8{sel_t2}} & t2_count_reg) |
      ({8{sel_t2c}} & t2_ctrl_reg) |
      port_read_sel; // R2 R10
   wire [7:0] read_value = ext_hit ? mem_rdata : read_local; // R1

   // read data register, holds until the next read is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= RST_WINDOW; // R2
      end else if (rd_take) begin
         hrdata_reg <= read_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs toward core and peripherals
   assign pc_value = {pc_high_reg, pc_low_reg}; // R7
   assign bank_select = status_reg[6:5];
   assign interrupt_control_out = int_ctrl_reg;
   assign timer_one_control_out = t1_ctrl_reg;
   assign timer_two_control_out = t2_ctrl_reg;
   assign timer_two_count_out = t2_count_reg;
endmodule

// ---- verilog/sfr_bank_pkg.sv ----
// Purpose: shared constants for the bank-zero special register block
// Assumes: register index = data-memory address, byte address = index * 4
// Notes: 9-bit data-memory address, two bank bits above a 7-bit offset
package sfr_bank_pkg;
   localparam int DATA_W = 8;
   localparam int MEM_ADDR_W = 9;
   localparam int ADDR_LSB = 2;
   localparam int PC_UPPER_W = 5;

   // register indices (low seven bits of a data-memory address)
   localparam logic [6:0] OFS_WINDOW = 7'h00;
   localparam logic [6:0] OFS_TIMER_ZERO = 7'h01;
   localparam logic [6:0] OFS_PC_LOW = 7'h02;
   localparam logic [6:0] OFS_STATUS = 7'h03;
   localparam logic [6:0] OFS_POINTER = 7'h04;
   localparam logic [6:0] OFS_PORT_A = 7'h05;
   localparam logic [6:0] OFS_PC_UPPER = 7'h0A;
   localparam logic [6:0] OFS_INT_CTRL = 7'h0B;
   localparam logic [6:0] OFS_FLAGS_ONE = 7'h0C;
   localparam logic [6:0] OFS_FLAGS_TWO = 7'h0D;
   localparam logic [6:0] OFS_T1_LOW = 7'h0E;
   localparam logic [6:0] OFS_T1_HIGH = 7'h0F;
   localparam logic [6:0] OFS_T1_CTRL = 7'h10;
   localparam logic [6:0] OFS_T2_COUNT = 7'h11;
   localparam logic [6:0] OFS_T2_CTRL = 7'h12;
   localparam logic [6:0] OFS_LAST = 7'h12;
   localparam logic [1:0] BANK_ZERO = 2'h0;

   // reset values
   localparam logic [7:0] RST_WINDOW = 8'h00;
   localparam logic [7:0] RST_PC_LOW = 8'h00;
   localparam logic [7:0] RST_STATUS_POR = 8'h18;
   localparam logic [4:0] RST_PC_UPPER = 5'h00;
   localparam logic [7:0] RST_INT_CTRL = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_T1_CTRL = 8'h00;
   localparam logic [7:0] RST_T2_COUNT = 8'h00;
   localparam logic [7:0] RST_T2_CTRL = 8'h00;
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_PORT = 8'h00;

   // field positions and masks
   localparam int STATUS_IRP_BIT = 7;
   localparam int STATUS_TO_BIT = 4;
   localparam int STATUS_PD_BIT = 3;
   localparam int FLAGS_PSP_BIT = 7;
   localparam int INT_FLAG_W = 3;
   localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
   localparam logic [7:0] INT_FLAG_MASK = 8'h07;
   localparam logic [7:0] FLAGS_ONE_MASK = 8'hF7;
   localparam logic [7:0] FLAGS_TWO_MASK = 8'h10;
   localparam logic [7:0] T1_CTRL_MASK = 8'h3F;
   localparam logic [7:0] T2_CTRL_MASK = 8'h7F;

   // storage-cell slots
   localparam int RAM_DEPTH = 4;
   localparam logic [1:0] SLOT_TIMER_ZERO = 2'h0;
   localparam logic [1:0] SLOT_T1_LOW = 2'h1;
   localparam logic [1:0] SLOT_T1_HIGH = 2'h2;

   // ports A to E
   localparam int PORT_COUNT = 5;
   localparam int PORT_WIDTH [PORT_COUNT] = '{6, 8, 8, 8, 3};
   localparam int PORT_D_INDEX = 3;

   // AHB-Lite
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// ---- verilog/sfr_cell_ram.sv ----
// Purpose: small static storage for plain data registers of the bank
// Assumes: one write and one read port, read data registered
// Notes: cells carry no reset, their power-up content is unknown
`timescale 1ns/10ps
module sfr_cell_ram #(
   parameter int DEPTH = 4,
   parameter int ADDR_W = 2,
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // write side
   input wire logic write_en,
   input wire logic [ADDR_W-1:0] write_addr,
   input wire logic [WIDTH-1:0] write_data,
   // read side
   input wire logic read_en,
   input wire logic [ADDR_W-1:0] read_addr,
   output logic [WIDTH-1:0] read_data_reg
);
   logic [WIDTH-1:0] cell_mem [DEPTH];

   // cell write, no reset so timer bytes keep value over soft resets
   always_ff @(posedge hclk) begin
      if (write_en) begin
         cell_mem[write_addr] <= write_data; // R3
      end
   end

   // registered read port
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_data_reg <= '0;
      end else if (read_en) begin
         read_data_reg <= cell_mem[read_addr]; // R3
      end
   end
endmodule

// ---- verilog/port_latch_block.sv ----
// Purpose: output latch of one I/O port with pin read-back
// Assumes: pin levels are synchronous to hclk
// Notes: an unbuilt port holds no latch and reads as zero
`timescale 1ns/10ps
module port_latch_block #(
   parameter int WIDTH = 8,
   parameter bit BUILT = 1'b1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register side
   input wire logic write_en,
   input wire logic [7:0] write_data,
   output logic [7:0] read_value,
   // pin side
   input wire logic [7:0] pins_in,
   output logic [7:0] latch_out_reg
);
   import sfr_bank_pkg::*;

   localparam logic [7:0] WIDTH_MASK = 8'((9'h001 << WIDTH) - 9'h001);
   localparam logic [7:0] BUILT_MASK = BUILT ? WIDTH_MASK : 8'h00;

   // writes land in the latch only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_out_reg <= RST_PORT;
      end else if (write_en) begin
         latch_out_reg <= write_data & BUILT_MASK; // R11 R9
      end
   end

   // reads show the pins, unbuilt and missing bits as zero
   assign read_value = pins_in & BUILT_MASK; // R11 R9 R10
endmodule

// ---- dv/sfr_bank_zero_assertions.sv ----
// Purpose: protocol and behaviour checks on the bank-zero register block ports
// Assumes: single clock domain, hresetn is the asynchronous power-up reset
// Notes: bound to the design from the bench top file
`timescale 1ns/10ps
module sfr_bank_zero_assertions (
   // clock and resets
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic soft_reset_n,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // core and memory side
   input wire logic pc_load,
   input wire logic [7:0] pc_load_low,
   input wire logic [12:0] pc_value,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [7:0] timer_two_count_out,
   input wire logic [7:0] timer_two_control_out,
   input wire logic [7:0] port_a_latch_out
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a transfer is taken at this edge
   wire take = hsel && hready && htrans[1];

   chk_read_waits: assert property (take && !hwrite |=> !hreadyout [*3] ##1 hreadyout)
      else $error("read wait count wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   chk_resp_okay: assert property (!hresp)
      else $error("error response seen");
   chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("unused read bits not zero");
   chk_pc_low_load: assert property (pc_load && soft_reset_n |=>
      pc_value[7:0] == $past(pc_load_low))
      else $error("pc low byte not loaded");
   chk_soft_clear: assert property (!soft_reset_n && !pc_load |=>
      pc_value == 13'h0 && timer_two_count_out == 8'h0 && timer_two_control_out == 8'h0)
      else $error("soft reset left values");
   chk_mem_we_pulse: assert property (mem_we |=> !mem_we)
      else $error("memory write strobe too long");
   chk_mem_re_pulse: assert property (mem_re |=> !mem_re && !mem_we)
      else $error("memory read strobe too long");
   chk_latch_cause: assert property ($changed(port_a_latch_out) |->
      $past(take && hwrite && haddr[10:2] == 9'h005, 2))
      else $error("latch changed without a write");

   // main scenarios reached
   cover property (take && !hwrite);
   cover property (mem_we);
   cover property (pc_load);
   cover property (!soft_reset_n);
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the bank-zero register block
// Assumes: one bus master, hready looped back from hreadyout
// Notes: expected values come from an integer model of the registers
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   import sfr_bank_pkg::*;
   logic hclk = 0, hresetn = 0, soft_reset_n = 1, reset_to_in = 0, reset_pd_in = 0;
   logic hsel = 0, hwrite = 0, pc_load = 0, hreadyout, hresp, mem_we, afw = 0, f2s = 0;
   logic [1:0] htrans = 0, bank_select;
   logic [2:0] hsize = 0, af = 0, ifs = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [7:0] pc_load_low = 0, mem_rdata = 0, mem_wdata, f1s = 0;
   logic [8:0] mem_addr;
   logic [12:0] pc_value;
   logic [7:0] pins [5] = '{default: 8'h00};
   logic [7:0] lat [5];
   logic [7:0] mdl [int];
   int n_fail = 0;
   int comparisons = 0;
   // registers given random contents
   logic [8:0] v_list [8] = '{9'h004, 9'h00E, 9'h00F, 9'h00A, 9'h010, 9'h011, 9'h012, 9'h001};

   special_register_bank_zero DUT (.hclk, .hresetn, .soft_reset_n, .reset_to_in, .reset_pd_in,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
      .hrdata, .hresp, .alu_flag_we(afw), .alu_flags(af), .pc_load, .pc_load_low,
      .pc_value, .bank_select, .int_flag_set(ifs), .flags_one_set(f1s),
      .flags_two_set(f2s), .interrupt_control_out(), .timer_one_control_out(),
      .timer_two_control_out(), .timer_two_count_out(), .mem_addr, .mem_wdata, .mem_we,
      .mem_re(), .mem_rdata, .port_a_pins_in(pins[0]), .port_b_pins_in(pins[1]),
      .port_c_pins_in(pins[2]), .port_d_pins_in(pins[3]), .port_e_pins_in(pins[4]),
      .port_a_latch_out(lat[0]), .port_b_latch_out(lat[1]), .port_c_latch_out(lat[2]),
      .port_d_latch_out(lat[3]), .port_e_latch_out(lat[4]));

   ////////////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      forever #10 hclk = ~hclk;
   end
   initial begin
      #(5000 * 20);
      n_fail++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // writable bits of each register
   function automatic logic [7:0] wmask(input logic [8:0] idx);
      case (idx[6:0])
         OFS_STATUS: return STATUS_WR_MASK;
         OFS_PC_UPPER: return 8'h1F;
         OFS_T1_CTRL: return T1_CTRL_MASK;
         OFS_T2_CTRL: return T2_CTRL_MASK;
         default: return 8'hFF;
      endcase
   endfunction

   // one single-word transfer, address phase then data phase
   task automatic bus(input logic [8:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
      int t;
      t = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {21'h0, idx, 2'h0};
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge hclk);
      while (!hreadyout && t < 50) begin
         @(posedge hclk);
         t++;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (!hreadyout && t < 50) begin
         @(posedge hclk);
         t++;
      end
      rd = hrdata[7:0];
      if (t >= 50) n_fail++;
   endtask

   // write and keep the model in step, ports excluded
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(idx, 1'b1, d, r);
      if (idx[6:0] != 7'h00 && (idx < 9'h005 || idx > 9'h009))
         mdl[idx] = (d & wmask(idx)) | (mdl[idx] & ~wmask(idx));
   endtask

   task automatic rd_chk(input logic [8:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(idx, 1'b0, 8'h00, r);
      `CHK(r, e)
   endtask

   task automatic sweep();
      foreach (mdl[k]) rd_chk(9'(k), mdl[k]);
   endtask

   task automatic close_out();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] v, u, p, tp;
      int i;
      void'($urandom(32'h47701E61));
      for (i = 0; i < 19; i++) mdl[i] = 8'h00;
      mdl[3] = RST_STATUS_POR;
      mdl[19] = 8'h00;
      mdl[127] = 8'h00;
      for (i = 5; i < 10; i++) mdl.delete(i);
      mdl.delete(1);
      mdl.delete(14);
      mdl.delete(15);
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      sweep();
      mdl.delete(0);
      foreach (v_list[i]) wr(v_list[i], 8'($urandom));
      sweep();
      rd_chk(9'h184, mdl[4]);
      rd_chk(9'h08A, mdl[10]);
      for (i = 0; i < PORT_COUNT; i++) begin
         v = 8'($urandom);
         pins[i] <= 8'($urandom);
         wr(9'(5 + i), v);
         u = 8'((1 << PORT_WIDTH[i]) - 1);
         rd_chk(9'(5 + i), pins[i] & u);
         `CHK(lat[i], v & u)
      end
      u = 8'($urandom);
      v = 8'($urandom);
      wr({BANK_ZERO, OFS_PC_UPPER}, u);
      pc_load <= 1'b1;
      pc_load_low <= v;
      @(posedge hclk);
      pc_load <= 1'b0;
      @(posedge hclk);
      `CHK(pc_value, {u[4:0], v})
      mdl[2] = v;
      rd_chk({BANK_ZERO, OFS_PC_UPPER}, u & 8'h1F);
      p = 8'h40 | 8'($urandom & 32'h3F);
      v = 8'($urandom);
      wr({BANK_ZERO, OFS_POINTER}, p);
      wr({BANK_ZERO, OFS_WINDOW}, v);
      @(posedge hclk);
      `CHK({mem_we, mem_addr, mem_wdata}, {1'b1, 1'b0, p, v})
      v = 8'($urandom);
      mem_rdata <= v;
      rd_chk({BANK_ZERO, OFS_WINDOW}, v);
      wr({BANK_ZERO, OFS_POINTER}, 8'h0E);
      rd_chk({BANK_ZERO, OFS_WINDOW}, mdl[14]);
      wr({BANK_ZERO, OFS_POINTER}, 8'h00);
      rd_chk({BANK_ZERO, OFS_WINDOW}, RST_WINDOW);
      tp = 8'($urandom & 32'h18);
      reset_to_in <= tp[4];
      reset_pd_in <= tp[3];
      soft_reset_n <= 1'b0;
      repeat (2) @(posedge hclk);
      soft_reset_n <= 1'b1;
      @(posedge hclk);
      `CHK(pc_value, 13'h0000)
      mdl[2] = 8'h00;
      mdl[3] = tp;
      for (i = 10; i < 14; i++) mdl[i] = 8'h00;
      mdl[17] = 8'h00;
      mdl[18] = 8'h00;
      sweep();
      tp = 8'($urandom);
      {afw, f2s, af, ifs, f1s} <= {2'h3, tp[2:0], tp[5:3], tp};
      @(posedge hclk);
      {afw, f2s, af, ifs, f1s} <= '0;
      mdl[3][2:0] = tp[2:0];
      mdl[11] = {5'h00, tp[5:3]};
      mdl[12] = tp & FLAGS_ONE_MASK;
      mdl[13] = FLAGS_TWO_MASK;
      sweep();
      wr({BANK_ZERO, OFS_STATUS}, 8'hFF);
      rd_chk({BANK_ZERO, OFS_STATUS}, mdl[3]);
      `CHK(bank_select, 2'h3)
      close_out();
   end
endmodule

bind special_register_bank_zero sfr_bank_zero_assertions chk (.hclk, .hresetn, .soft_reset_n,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .pc_load,
   .pc_load_low, .pc_value, .mem_we, .mem_re, .timer_two_count_out, .timer_two_control_out,
   .port_a_latch_out);
